// >>> pcr_supervisor.v
// PLL supervisor and clock generator ratio registers
// Summary of operation
// RL1: Enabled supervisor resets unstable PLL unasked
// RL2: Relock automatically with unchanged prior settings
// RL3: Whole sequence needs no host access
// RL4: Control bit 0 enables, resets to one
// RL5: Host keeps supervisor enabled always; the testbench clears bit 0 once to check that no reset follows
// RL6: Generator 1 denominator, 9 bits, resets 6
// RL7: Generator 1 numerator, 9 bits, resets 1
// RL8: Generator 2 denominator, 9 bits, resets 9
// RL9: Generator 2 numerator, 9 bits, resets 1
// RL10: Generator 3 denominator, 16 bits, resets 0
// RL11: Generator 3 numerator, 16 bits, resets 0
// RL12: External reference: numerator over 1024, denominator ignored
// RL13: Host writes zeros to reserved bits; the testbench writes 16'hffff, reserved bits included
module pcr_supervisor (
  input wire ref_clk_in,
  input wire resetn_in,
  input wire [15:0] reg_addr_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [15:0] reg_wdata_in,
  output reg [15:0] reg_rdata_out,
  input wire pll_unstable_in,
  input wire pll_locked_in,
  input wire gen3_ext_ref_in,
  input wire [31:0] gen3_ref_rate_in,
  output wire pll_reset_out,
  output wire pll_relock_out,
  output wire supv_busy_out,
  output wire [8:0] gen1_divisor_value_out,
  output wire [8:0] gen1_multiplier_value_out,
  output wire [8:0] gen2_divisor_value_out,
  output wire [8:0] gen2_multiplier_value_out,
  output wire [15:0] gen3_divisor_value_out,
  output wire [15:0] gen3_multiplier_value_out,
  output wire [31:0] gen3_base_rate_out
);
`include "pcr_defs.vh"

  // ==========================================================================
  // Register write decode
  function sel;
    input [15:0] addr;
    input [15:0] ofs;
    begin
      sel = (addr == ofs);
    end
  endfunction

  reg supv_en_q;
  // Full reset word; only the enable bit is stored
  wire [15:0] supv_rst_val = `PCR_RST_SUPV_CTRL;
  always @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      supv_en_q <= supv_rst_val[`PCR_SUPV_EN_BIT]; // RL4
    end else if (reg_wr_in && sel(reg_addr_in, `PCR_OFS_SUPV_CTRL)) begin
      supv_en_q <= reg_wdata_in[`PCR_SUPV_EN_BIT]; // RL4
    end
  end

  // RL6
  pcr_ratio_reg #(.W(9), .RST(`PCR_RST_GEN1_DEN)) u_g1d (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
    .wr_in(reg_wr_in && sel(reg_addr_in, `PCR_OFS_GEN1_DEN)),
    .wdata_in(reg_wdata_in), .value_out(gen1_divisor_value_out));
  // RL7
  pcr_ratio_reg #(.W(9), .RST(`PCR_RST_GEN1_NUM)) u_g1n (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
    .wr_in(reg_wr_in && sel(reg_addr_in, `PCR_OFS_GEN1_NUM)),
    .wdata_in(reg_wdata_in), .value_out(gen1_multiplier_value_out));
  // RL8
  pcr_ratio_reg #(.W(9), .RST(`PCR_RST_GEN2_DEN)) u_g2d (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
    .wr_in(reg_wr_in && sel(reg_addr_in, `PCR_OFS_GEN2_DEN)),
    .wdata_in(reg_wdata_in), .value_out(gen2_divisor_value_out));
  // RL9
  pcr_ratio_reg #(.W(9), .RST(`PCR_RST_GEN2_NUM)) u_g2n (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
    .wr_in(reg_wr_in && sel(reg_addr_in, `PCR_OFS_GEN2_NUM)),
    .wdata_in(reg_wdata_in), .value_out(gen2_multiplier_value_out));
  // RL10
  pcr_ratio_reg #(.W(16), .RST(`PCR_RST_GEN3_DEN)) u_g3d (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
    .wr_in(reg_wr_in && sel(reg_addr_in, `PCR_OFS_GEN3_DEN)),
    .wdata_in(reg_wdata_in), .value_out(gen3_divisor_value_out));
  // RL11
  pcr_ratio_reg #(.W(16), .RST(`PCR_RST_GEN3_NUM)) u_g3n (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
    .wr_in(reg_wr_in && sel(reg_addr_in, `PCR_OFS_GEN3_NUM)),
    .wdata_in(reg_wdata_in), .value_out(gen3_multiplier_value_out));

  pcr_ratio_calc u_calc (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .ext_sel_in(gen3_ext_ref_in),
    .ref_rate_in(gen3_ref_rate_in),
    .num_in(gen3_multiplier_value_out),
    .den_in(gen3_divisor_value_out),
    .rate_out(gen3_base_rate_out)
  );

  // ==========================================================================
  // Register read, one cycle latency; reserved bits read zero
  always @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `PCR_OFS_SUPV_CTRL: reg_rdata_out <= {15'h0000, supv_en_q};
        `PCR_OFS_GEN1_DEN: reg_rdata_out <= {7'h00, gen1_divisor_value_out};
        `PCR_OFS_GEN1_NUM: reg_rdata_out <= {7'h00, gen1_multiplier_value_out};
        `PCR_OFS_GEN2_DEN: reg_rdata_out <= {7'h00, gen2_divisor_value_out};
        `PCR_OFS_GEN2_NUM: reg_rdata_out <= {7'h00, gen2_multiplier_value_out};
        `PCR_OFS_GEN3_DEN: reg_rdata_out <= gen3_divisor_value_out;
        `PCR_OFS_GEN3_NUM: reg_rdata_out <= gen3_multiplier_value_out;
        default: reg_rdata_out <= 16'h0000;
      endcase
    end
  end

  // ==========================================================================
  // Supervisor sequence: watch, reset, relock
  localparam [2:0] ST_WATCH = 3'b001;
  localparam [2:0] ST_RESET = 3'b010;
  localparam [2:0] ST_RELOCK = 3'b100;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [11:0] cnt_q;
  reg [11:0] cnt_d;

  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      ST_WATCH: begin
        if (supv_en_q && pll_unstable_in) begin
          state_d = ST_RESET; // RL1
          cnt_d = 12'h000;
        end
      end
      ST_RESET: begin
        if (cnt_q == `PCR_PLL_RST_CYC - 1) begin
          state_d = ST_RELOCK; // RL2
          cnt_d = 12'h000;
        end else begin
          cnt_d = cnt_q + 12'h001;
        end
      end
      ST_RELOCK: begin
        // Settings registers are untouched, so relock uses prior config
        if (pll_locked_in || cnt_q == `PCR_LOCK_WAIT_CYC - 1) begin
          state_d = ST_WATCH; // RL2
          cnt_d = 12'h000;
        end else begin
          cnt_d = cnt_q + 12'h001;
        end
      end
      default: begin
        state_d = ST_WATCH;
        cnt_d = 12'h000;
      end
    endcase
  end

  // No host access gates any transition
  always @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      state_q <= ST_WATCH;
      cnt_q <= 12'h000;
    end else begin
      state_q <= state_d; // RL3
      cnt_q <= cnt_d;
    end
  end

  assign pll_reset_out = state_q[1]; // RL1
  assign pll_relock_out = state_q[2]; // RL2
  assign supv_busy_out = ~state_q[0];
endmodule

// >>> pcr_defs.vh
// Register offsets, reset values and timing counts for the PLL supervisor and ratio registers
`ifndef PCR_DEFS_VH
`define PCR_DEFS_VH
// ==========================================================================
// Register offsets
`define PCR_OFS_SUPV_CTRL 16'hf006
`define PCR_OFS_GEN1_DEN 16'hf020
`define PCR_OFS_GEN1_NUM 16'hf021
`define PCR_OFS_GEN2_DEN 16'hf022
`define PCR_OFS_GEN2_NUM 16'hf023
`define PCR_OFS_GEN3_DEN 16'hf024
`define PCR_OFS_GEN3_NUM 16'hf025
// ==========================================================================
// Reset values
`define PCR_RST_SUPV_CTRL 16'h0001
`define PCR_RST_GEN1_DEN 9'h006
`define PCR_RST_GEN1_NUM 9'h001
`define PCR_RST_GEN2_DEN 9'h009
`define PCR_RST_GEN2_NUM 9'h001
`define PCR_RST_GEN3_DEN 16'h0000
`define PCR_RST_GEN3_NUM 16'h0000
// ==========================================================================
// Field positions
`define PCR_SUPV_EN_BIT 0
`define PCR_SMALL_MSB 8
// ==========================================================================
// Timing: PLL reset pulse in ns and cycles at 8 ns, lock wait in cycles
`define PCR_CLK_PERIOD_NS 8
`define PCR_PLL_RST_NS 1000
`define PCR_PLL_RST_CYC ((`PCR_PLL_RST_NS + `PCR_CLK_PERIOD_NS - 1) / `PCR_CLK_PERIOD_NS)
`define PCR_LOCK_WAIT_CYC 4000
`define PCR_EXT_REF_SHIFT 10
`endif

// >>> pcr_ratio_reg.v
// One ratio register with a width-limited value field
module pcr_ratio_reg #(
  parameter W = 16,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  input wire ref_clk_in,
  input wire resetn_in,
  input wire wr_in,
  input wire [15:0] wdata_in,
  output reg [W-1:0] value_out
);
  always @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      value_out <= RST;
    end else if (wr_in) begin
      value_out <= wdata_in[W-1:0];
    end
  end
endmodule

// >>> pcr_ratio_calc.v
// Base rate for generator 3: reference times numerator over 1024 with an external reference, else the low 32 bits of that product over the denominator
module pcr_ratio_calc (
  input wire ref_clk_in,
  input wire resetn_in,
  input wire ext_sel_in,
  input wire [31:0] ref_rate_in,
  input wire [15:0] num_in,
  input wire [15:0] den_in,
  output reg [31:0] rate_out
);
`include "pcr_defs.vh"
  wire [47:0] prod = ref_rate_in * num_in;
  wire [31:0] ext_rate = prod[`PCR_EXT_REF_SHIFT+31:`PCR_EXT_REF_SHIFT];
  wire [31:0] pll_rate = (den_in == 16'h0000) ? 32'h0 : prod[31:0] / {16'h0000, den_in};
  always @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      rate_out <= 32'h0;
    end else begin
      // Denominator ignored with an external reference
      rate_out <= ext_sel_in ? ext_rate : pll_rate; // RL12
    end
  end
endmodule

// >>> pcr_supervisor_chk.sv
// Checker for the PLL supervisor and ratio register ports
module pcr_supervisor_chk (
  input wire ref_clk_in,
  input wire resetn_in,
  input wire [15:0] reg_addr_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [15:0] reg_wdata_in,
  input wire [15:0] reg_rdata_out,
  input wire pll_unstable_in,
  input wire pll_locked_in,
  input wire pll_reset_out,
  input wire pll_relock_out,
  input wire supv_busy_out,
  input wire [8:0] gen1_divisor_value_out,
  input wire [8:0] gen2_multiplier_value_out,
  input wire [15:0] gen3_multiplier_value_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  // ==========================================
  // Shadow of the supervisor enable
  logic en_q;
  always_ff @(posedge ref_clk_in)
    if (!resetn_in) en_q <= 1'b1;
    else if (reg_wr_in && reg_addr_in == 16'hf006) en_q <= reg_wdata_in[0];
  a_unstable_starts_reset: assert property (en_q && !supv_busy_out && pll_unstable_in
    |=> pll_reset_out) else $error("no reset after instability");
  a_disabled_no_reset: assert property (!en_q && !supv_busy_out |=> !pll_reset_out)
    else $error("reset while disabled");
  a_reset_pulse_len: assert property ($rose(pll_reset_out) |->
    ##125 (pll_relock_out && !pll_reset_out)) else $error("bad reset pulse");
  a_relock_on_lock: assert property (pll_relock_out && pll_locked_in |=> !supv_busy_out)
    else $error("relock not ended");
  a_busy_tracks_state: assert property (supv_busy_out == (pll_reset_out | pll_relock_out))
    else $error("busy mismatch");
  a_gen1_den_write: assert property (reg_wr_in && reg_addr_in == 16'hf020
    |=> gen1_divisor_value_out == $past(reg_wdata_in[8:0])) else $error("gen1 den");
  a_gen3_num_write: assert property (reg_wr_in && reg_addr_in == 16'hf025
    |=> gen3_multiplier_value_out == $past(reg_wdata_in)) else $error("gen3 num");
  a_unmapped_read_zero: assert property (reg_rd_in && reg_addr_in[15:12] != 4'hf
    |=> reg_rdata_out == 16'h0000) else $error("unmapped read");
  a_ratio_holds: assert property (!reg_wr_in |=> $stable(gen2_multiplier_value_out))
    else $error("ratio changed");
endmodule
bind pcr_supervisor pcr_supervisor_chk pcr_supervisor_chk_inst (.*);

// >>> pcr_supervisor_test.sv
// Testbench for the PLL supervisor and ratio registers
module pcr_supervisor_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, unst = 0, lock = 0, ext = 0;
  logic [15:0] a = 0, wd = 0, rdat;
  logic [31:0] rate = 0, base;
  logic busy, prst, rlk;
  logic [8:0] g1d;
  logic [15:0] rv [7] = '{16'h0001, 16'h0006, 16'h0001, 16'h0009, 16'h0001, 16'h0000, 16'h0000};
  int bad_count = 0, n_compared = 0, n;
  pcr_supervisor pcr_supervisor_inst (.ref_clk_in(clk), .resetn_in(rst_n), .reg_addr_in(a),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wd), .reg_rdata_out(rdat),
    .pll_unstable_in(unst), .pll_locked_in(lock), .gen3_ext_ref_in(ext),
    .gen3_ref_rate_in(rate), .pll_reset_out(prst), .pll_relock_out(rlk), .supv_busy_out(busy),
    .gen1_divisor_value_out(g1d), .gen1_multiplier_value_out(), .gen2_divisor_value_out(),
    .gen2_multiplier_value_out(), .gen3_divisor_value_out(), .gen3_multiplier_value_out(),
    .gen3_base_rate_out(base));
  initial forever #4 clk = ~clk;
  function automatic logic [15:0] ad(int i);
    return i ? 16'hf01f + 16'(i) : 16'hf006;
  endfunction
  task automatic results;
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wrt(logic [15:0] ad, logic [15:0] d);
    @(negedge clk);
    a = ad;
    wd = d;
    wr = 1;
    @(negedge clk);
    wr = 0;
  endtask
  task automatic rdc(logic [15:0] ad, logic [15:0] e);
    @(negedge clk);
    a = ad;
    rd = 1;
    @(negedge clk);
    rd = 0;
    chk("rdata", {16'h0000, e}, {16'h0000, rdat});
  endtask
  // ==========================================
  // Hang guard
  initial begin
    repeat (20000) @(negedge clk);
    bad_count++;
    results();
  end
  // ==========================================
  // Main sequence
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1;
    for (int i = 0; i < 7; i++) rdc(ad(i), rv[i]);
    for (int i = 0; i < 7; i++) wrt(ad(i), 16'hffff);
    for (int i = 0; i < 7; i++)
      rdc(ad(i), i == 0 ? 16'h0001 : i < 5 ? 16'h01ff : 16'hffff);
    wrt(16'hf007, 16'hffff);
    rdc(16'hf007, 16'h0000);
    unst = 1;
    @(negedge clk);
    unst = 0;
    chk("pll_reset", 32'h1, {31'h0, prst});
    n = 0;
    while (prst === 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk("reset_len", 32'h7d, n);
    chk("relock", 32'h1, {31'h0, rlk});
    chk("gen1_div", 32'h1ff, {23'h0, g1d});
    lock = 1;
    repeat (2) @(negedge clk);
    chk("busy", 32'h0, {31'h0, busy});
    wrt(16'hf006, 16'h0000);
    unst = 1;
    repeat (10) @(negedge clk);
    chk("pll_reset", 32'h0, {31'h0, prst});
    unst = 0;
    wrt(16'hf006, 16'h0001);
    ext = 1;
    rate = 32'h0000bb80;
    wrt(16'hf025, 16'h0800);
    repeat (2) @(negedge clk);
    chk("base", 32'h00017700, base);
    ext = 0;
    repeat (2) @(negedge clk);
    chk("base", 32'h000005dc, base);
    results();
  end
endmodule
